// ### rtl/sfq_top.v
// sfq_top.v: two independent synchronous fifo banks with flag timing modes,
// apb register file and one interrupt output.
// assumes write/read clock pins are slow levels synchronous to i_clk_sys.
//
// Overview of operation
// - synchronous almost-empty updates on read edges only
// - synchronous almost-full updates on write edges only
// - close write edge may delay almost-empty release
// - close read edge may delay almost-full release
// - depth 256 standard, 257 with fall-through
// - double-buffered full releases one write edge later
// - double-buffered empty releases one read edge later
// - close read edge may delay full release
// - fall-through presents first word without read request
`timescale 1ns/1ns
`include "sfq_defines.vh"

module sfq_top (
  // clock, reset, enable
  input  wire                        i_clk_sys,
  input  wire                        i_srst,
  input  wire                        i_clk_en,
  // apb slave
  input  wire                        i_psel,
  input  wire                        i_penable,
  input  wire                        i_pwrite,
  input  wire [7:0]                  i_paddr,
  input  wire [31:0]                 i_pwdata,
  output reg  [31:0]                 o_prdata,
  output reg                         o_pready,
  output reg                         o_pslverr,
  // write ports, one bit or field per bank
  input  wire [1:0]                  i_write_clock,
  input  wire [1:0]                  i_wr_en,
  input  wire [2*`SFQ_DW-1:0]        i_wr_data,
  input  wire [1:0]                  i_offset_load_strobe,
  // read ports
  input  wire [1:0]                  i_read_clock,
  input  wire [1:0]                  i_rd_en,
  output wire [2*`SFQ_DW-1:0]        o_rd_data,
  // reset-time configuration
  input  wire [1:0]                  i_chain_head_select,
  input  wire [1:0]                  i_read_chain_in,
  input  wire [1:0]                  i_write_chain_in,
  // flags, active high
  output wire [1:0]                  o_empty_indicator,
  output wire [1:0]                  o_full_indicator,
  output wire [1:0]                  o_almost_empty_flag,
  output wire [1:0]                  o_almost_full_flag,
  // interrupt
  output reg                         o_irq
);

  reg  [31:0] status;
  reg  [31:0] irq_mask;
  reg  [15:0] ae_off;
  reg  [15:0] af_off;
  wire [31:0] ev_all;
  wire [31:0] cfg_view;
  wire [31:0] level_view;

  genvar b;
  generate
    for (b = 0; b < `SFQ_NBANK; b = b + 1) begin : g_bank
      reg  [`SFQ_PW-1:0] wptr;
      reg  [`SFQ_PW-1:0] rptr;
      reg  [`SFQ_PW-1:0] rptr_w;
      reg  [`SFQ_PW-1:0] wptr_r;
      reg                wq;
      reg                rq;
      reg                ov;
      reg                ov_w;
      reg                full_r;
      reg                full_s1;
      reg                empty_r;
      reg                empty_s1;
      reg                ae_r;
      reg                af_r;
      reg  [2:0]         cfg;
      reg  [`SFQ_DW-1:0] dq;
      wire [`SFQ_DW-1:0] ram_q;

      // decoded modes
      wire sync_pf = (cfg == `SFQ_CFG_SPF_A) | (cfg == `SFQ_CFG_SPF_B) |
                     (cfg == `SFQ_CFG_SPF_C);
      wire dbl     = (cfg == `SFQ_CFG_DBL_A) | (cfg == `SFQ_CFG_DBL_B);
      wire fall_through_mode    = (cfg == `SFQ_CFG_FT_A)  | (cfg == `SFQ_CFG_FT_B);
      wire bad_cfg = (cfg == `SFQ_CFG_BAD_A) | (cfg == `SFQ_CFG_BAD_B);

      // pin clock edges
      wire wr_edge = i_write_clock[b] & ~wq;
      wire rd_edge = i_read_clock[b] & ~rq;

      // write side, sees the read pointer one cycle late
      wire               wr_try  = wr_edge & i_wr_en[b] & ~i_offset_load_strobe[b];
      wire               wr_ok   = wr_try & ~full_r & ~bad_cfg;
      wire [`SFQ_PW-1:0] mem_w   = wptr - rptr_w;
      wire [`SFQ_PW-1:0] mem_wn  = mem_w + {8'h00, wr_ok};
      wire               full_n  = (mem_wn == `SFQ_DEPTH);
      wire [9:0]         lvl_wn  = {1'b0, mem_wn} + {9'h000, ov_w};
      // fall-through adds the output register to the usable depth
      wire [9:0]         dep_tot = {1'b0, `SFQ_DEPTH} + {9'h000, fall_through_mode};
      wire               af_n    = lvl_wn >= (dep_tot - {2'b00, af_off[8*b +: 8]});

      // read side, sees the write pointer one cycle late
      wire               mem_ne  = (wptr_r != rptr);
      wire               rd_ok   = rd_edge & i_rd_en[b] & ~empty_r & ~fall_through_mode;
      wire               ld_ft   = rd_edge & fall_through_mode & mem_ne & (~ov | i_rd_en[b]);
      wire               take_ft = rd_edge & fall_through_mode & ov & i_rd_en[b];
      wire               pop     = rd_ok | ld_ft;
      wire               next_ov = ld_ft ? 1'b1 : (take_ft ? 1'b0 : ov);
      wire [`SFQ_PW-1:0] mem_rn  = wptr_r - rptr - {8'h00, pop};
      wire               empty_n = (mem_rn == {`SFQ_PW{1'b0}});
      wire [9:0]         lvl_rn  = {1'b0, mem_rn} + {9'h000, next_ov};
      wire               ae_n    = lvl_rn <= {2'b00, ae_off[8*b +: 8]};
      wire               next_empty = fall_through_mode ? ~next_ov : (empty_n | (dbl & empty_s1));

      sfq_ram u_ram (
        .i_clk_sys (i_clk_sys),
        .i_clk_en  (i_clk_en),
        .i_we      (wr_ok),
        .i_waddr   (wptr[`SFQ_PW-2:0]),
        .i_wdata   (i_wr_data[`SFQ_DW*b +: `SFQ_DW]),
        .i_raddr   (rptr[`SFQ_PW-2:0]),
        .o_rdata   (ram_q)
      );

      // each bank keeps its own pointers, flags and captured code
      always @(posedge i_clk_sys) begin
        if (i_srst) begin
          // code is sampled while reset is held
          cfg      <= {i_chain_head_select[b], i_read_chain_in[b],
                       i_write_chain_in[b]};
          wptr     <= {`SFQ_PW{1'b0}};
          rptr     <= {`SFQ_PW{1'b0}};
          rptr_w   <= {`SFQ_PW{1'b0}};
          wptr_r   <= {`SFQ_PW{1'b0}};
          wq       <= 1'b1;
          rq       <= 1'b1;
          ov       <= 1'b0;
          ov_w     <= 1'b0;
          full_r   <= 1'b0;
          full_s1  <= 1'b0;
          empty_r  <= 1'b1;
          empty_s1 <= 1'b1;
          ae_r     <= 1'b1;
          af_r     <= 1'b0;
          dq       <= {`SFQ_DW{1'b0}};
        end else if (i_clk_en) begin
          wq <= i_write_clock[b];
          rq <= i_read_clock[b];
          // one-cycle crossing view: an opposite edge closer than the
          // skew minimum is seen only on the following edge
          rptr_w <= rptr;
          ov_w   <= ov;
          wptr_r <= wptr;
          if (wr_ok) begin
            wptr <= wptr + 9'h001;
          end
          if (wr_edge) begin
            // assert at once, release one write edge late when double
            full_s1 <= full_n;
            full_r  <= full_n | (dbl & full_s1);
          end
          // almost-full: write edges only in synchronous mode
          if (wr_edge || !sync_pf) begin
            af_r <= af_n;
          end
          if (pop) begin
            rptr <= rptr + 9'h001;
            dq   <= ram_q;
          end
          if (rd_edge) begin
            // fall-through loads the head word with no read request
            ov       <= next_ov;
            empty_s1 <= empty_n;
            empty_r  <= next_empty;
          end
          // almost-empty: read edges only in synchronous mode
          if (rd_edge || !sync_pf) begin
            ae_r <= ae_n;
          end
        end
      end

      // events: full, data ready, almost-full, almost-empty, write refused
      wire [`SFQ_EV_W-1:0] ev = {
        wr_try & (full_r | bad_cfg),
        rd_edge & ae_n & ~ae_r & (sync_pf | 1'b1),
        af_n & ~af_r & (wr_edge | ~sync_pf),
        rd_edge & ~next_empty & empty_r,
        wr_edge & full_n & ~full_r
      };

      assign ev_all[`SFQ_EV_STRIDE*b +: `SFQ_EV_STRIDE] = {3'b000, ev};
      assign ev_all[16+`SFQ_EV_STRIDE*b +: `SFQ_EV_STRIDE] = 8'h00;
      assign cfg_view[8*b +: 8] = {3'b000, bad_cfg, fall_through_mode, cfg};
      assign cfg_view[16+8*b +: 8] = 8'h00;
      assign level_view[16*b +: 16] = {6'h00, lvl_rn};
      assign o_rd_data[`SFQ_DW*b +: `SFQ_DW] = dq;
      assign o_empty_indicator[b]   = empty_r;
      assign o_full_indicator[b]    = full_r;
      assign o_almost_empty_flag[b] = ae_r;
      assign o_almost_full_flag[b]  = af_r;
    end
  endgenerate

  // apb: one wait state, access completes when pready is seen high
  wire        acc_pend = i_psel & i_penable & ~o_pready;
  wire        acc_done = i_psel & i_penable & o_pready;
  wire        wr_done  = acc_done & i_pwrite;
  wire [31:0] w1c      = (wr_done && i_paddr == `SFQ_REG_STATUS) ? i_pwdata : 32'h00000000;
  // set wins over a same-cycle clear
  wire [31:0] next_status = (status & ~w1c) | ev_all;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  always @* begin
    rd_mux  = 32'h00000000;
    addr_ok = 1'b1;
    case (i_paddr)
      `SFQ_REG_STATUS: rd_mux = status;
      `SFQ_REG_MASK:   rd_mux = irq_mask;
      `SFQ_REG_CONFIG: rd_mux = cfg_view;
      `SFQ_REG_AEOFF:  rd_mux = {16'h0000, ae_off};
      `SFQ_REG_AFOFF:  rd_mux = {16'h0000, af_off};
      `SFQ_REG_LEVEL:  rd_mux = level_view;
      default:         addr_ok = 1'b0;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      status    <= 32'h00000000;
      irq_mask  <= `SFQ_MASK_RST;
      ae_off    <= {`SFQ_OFF_RST, `SFQ_OFF_RST};
      af_off    <= {`SFQ_OFF_RST, `SFQ_OFF_RST};
      o_prdata  <= 32'h00000000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq     <= 1'b0;
    end else if (i_clk_en) begin
      o_pready  <= acc_pend;
      o_pslverr <= acc_pend & ~addr_ok;
      o_prdata  <= (acc_pend && !i_pwrite) ? rd_mux : 32'h00000000;
      status    <= next_status;
      o_irq     <= |(next_status & irq_mask);
      if (wr_done) begin
        case (i_paddr)
          `SFQ_REG_MASK:  irq_mask <= i_pwdata;
          `SFQ_REG_AEOFF: ae_off   <= i_pwdata[15:0];
          `SFQ_REG_AFOFF: af_off   <= i_pwdata[15:0];
          default:        ae_off   <= ae_off;
        endcase
      end
    end
  end

endmodule

// ### rtl/sfq_defines.vh
// sfq_defines.vh: constants for the dual synchronous fifo bank block.
// assumes inclusion by bare name from every rtl file that needs them.
`ifndef SFQ_DEFINES_VH
`define SFQ_DEFINES_VH

// array geometry, per bank
`define SFQ_DW         18
`define SFQ_PW         9
`define SFQ_DEPTH      9'h100
`define SFQ_NBANK      2

// timing: system clock and skew minima, cycles derived (least time rounds up)
`define SFQ_CLK_NS     50
`define SFQ_SKEW1_NS   50
`define SFQ_SKEW2_NS   50
`define SFQ_SKEW1_CYC  ((`SFQ_SKEW1_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS)
`define SFQ_SKEW2_CYC  ((`SFQ_SKEW2_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS)

// reset-time codes {chain_head_select, read_chain_in, write_chain_in}
`define SFQ_CFG_SPF_A  3'h4
`define SFQ_CFG_SPF_B  3'h5
`define SFQ_CFG_SPF_C  3'h6
`define SFQ_CFG_DBL_A  3'h2
`define SFQ_CFG_DBL_B  3'h6
`define SFQ_CFG_FT_A   3'h1
`define SFQ_CFG_FT_B   3'h5
`define SFQ_CFG_BAD_A  3'h3
`define SFQ_CFG_BAD_B  3'h7

// apb register byte offsets
`define SFQ_REG_STATUS 8'h00
`define SFQ_REG_MASK   8'h04
`define SFQ_REG_CONFIG 8'h08
`define SFQ_REG_AEOFF  8'h0c
`define SFQ_REG_AFOFF  8'h10
`define SFQ_REG_LEVEL  8'h14

// status layout: five event bits per bank, bank b at bit 8*b
`define SFQ_EV_W       5
`define SFQ_EV_STRIDE  8
`define SFQ_OFF_RST    8'h07
`define SFQ_MASK_RST   32'h00000000

`endif

// ### rtl/sfq_ram.v
// sfq_ram.v: one bank's storage, synchronous write, combinational read.
// assumes the caller gates writes and keeps addresses in range.
`timescale 1ns/1ns
`include "sfq_defines.vh"

module sfq_ram (
  // clock
  input  wire                 i_clk_sys,
  input  wire                 i_clk_en,
  // write port
  input  wire                 i_we,
  input  wire [`SFQ_PW-2:0]   i_waddr,
  input  wire [`SFQ_DW-1:0]   i_wdata,
  // read port
  input  wire [`SFQ_PW-2:0]   i_raddr,
  output wire [`SFQ_DW-1:0]   o_rdata
);

  reg [`SFQ_DW-1:0] mem [0:255];

  // no reset on the array: contents are undefined until written
  always @(posedge i_clk_sys) begin
    if (i_clk_en && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule

// ### bench/sfq_props.sv
// checker: flag edge timing and apb answer of sfq_top.
// assumes pin clocks are slow levels, sampled the way the design samples them.
`timescale 1ns/1ns
module sfq_props (
  // clock, reset
  input wire        i_clk_sys,
  input wire        i_srst,
  // pins watched
  input wire [1:0]  i_write_clock,
  input wire [1:0]  i_read_clock,
  input wire [1:0]  i_chain_head_select,
  input wire [1:0]  i_read_chain_in,
  input wire [1:0]  i_write_chain_in,
  input wire        i_penable,
  // outputs watched
  input wire        o_pready,
  input wire [35:0] o_rd_data,
  input wire [1:0]  o_empty_indicator,
  input wire [1:0]  o_full_indicator,
  input wire [1:0]  o_almost_empty_flag,
  input wire [1:0]  o_almost_full_flag
);
  reg  [1:0] wq;
  reg  [1:0] rq;
  reg  [1:0] syn;
  wire [1:0] wr = i_write_clock & ~wq;
  wire [1:0] rr = i_read_clock & ~rq;
  // pins count as high in reset, so no edge is seen at release
  always @(posedge i_clk_sys) begin
    wq <= i_srst ? 2'h3 : i_write_clock;
    rq <= i_srst ? 2'h3 : i_read_clock;
    if (i_srst)
      syn <= i_chain_head_select & ~(i_read_chain_in & i_write_chain_in);
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  ae_read_edge_a: assert property (syn[0] && $changed(o_almost_empty_flag[0])
    |-> $past(rr[0]) || $past(rr[0], 2)) else $error("almost-empty off read edge");
  af_write_edge_a: assert property (syn[0] && $changed(o_almost_full_flag[0])
    |-> $past(wr[0]) || $past(wr[0], 2)) else $error("almost-full off write edge");
  af_bank_one_a: assert property (syn[1] && $changed(o_almost_full_flag[1])
    |-> $past(wr[1]) || $past(wr[1], 2)) else $error("bank 1 almost-full off write edge");
  full_release_a: assert property ($fell(o_full_indicator[0])
    |-> $past(wr[0]) || $past(wr[0], 2)) else $error("full released off write edge");
  empty_release_a: assert property ($fell(o_empty_indicator[0])
    |-> $past(rr[0]) || $past(rr[0], 2)) else $error("empty released off read edge");
  ft_ready_edge_a: assert property ($fell(o_empty_indicator[1])
    |-> $past(rr[1]) || $past(rr[1], 2)) else $error("ready off read edge");
  ft_data_edge_a: assert property ($changed(o_rd_data[35:18])
    |-> $past(rr[1]) || $past(rr[1], 2) || $past(rr[1], 3)) else $error("word off read edge");
  apb_answer_a: assert property ($rose(i_penable) |-> ##1 o_pready ##1 !o_pready)
    else $error("apb answer not one wait state");
endmodule

bind sfq_top sfq_props u_props (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_write_clock(i_write_clock),
  .i_read_clock(i_read_clock), .i_chain_head_select(i_chain_head_select),
  .i_read_chain_in(i_read_chain_in), .i_write_chain_in(i_write_chain_in),
  .i_penable(i_penable), .o_pready(o_pready), .o_rd_data(o_rd_data),
  .o_empty_indicator(o_empty_indicator), .o_full_indicator(o_full_indicator),
  .o_almost_empty_flag(o_almost_empty_flag), .o_almost_full_flag(o_almost_full_flag)
);

// ### bench/sfq_far_end.sv
// partner: free-running pin clocks and enables for both banks.
// assumes the bench sets i_want right after a rising edge.
`timescale 1ns/1ns
module sfq_far_end #(
  parameter HALF = 2
) (
  // clock
  input  wire       i_clk_sys,
  // requests: write bank 0/1, read bank 0/1
  input  wire [3:0] i_want,
  // pins and handshake
  output reg  [3:0] o_pin,
  output wire [3:0] o_en,
  output wire [3:0] o_done
);
  reg     [3:0] last = 4'h0;
  integer       cnt = 0;
  integer       k;
  assign o_en   = i_want;
  assign o_done = o_pin & ~last & i_want;
  initial o_pin = 4'h0;
  // distinct periods slide the two sides past each other
  always @(posedge i_clk_sys) begin
    cnt  <= cnt + 1;
    last <= o_pin;
    for (k = 0; k < 4; k = k + 1)
      if (cnt % (HALF + k) == 0)
        o_pin[k] <= ~o_pin[k];
  end
endmodule

// ### bench/sfq_top_tb_top.sv
// bench: apb master, stimulus and checks for sfq_top.
// assumes sfq_far_end makes the pin clocks and enables.
`timescale 1ns/1ns
`include "sfq_defines.vh"
module sfq_top_tb_top;
  reg         i_clk_sys = 1'b0;
  reg         i_srst    = 1'b1;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg  [7:0]  paddr     = 8'h00;
  reg  [31:0] pwdata    = 32'h00000000, rd;
  reg  [35:0] wdata     = 36'h000000000;
  reg  [3:0]  want      = 4'h0;
  reg  [1:0]  ldstb     = 2'h0;
  reg  [31:0] seed      = 32'h4a6cbd23;
  reg  [17:0] q[$];
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [35:0] rdata;
  wire [1:0]  empty, full, aempty, afull;
  wire [3:0]  pin, en, done;
  integer     errors = 0;
  integer     comparisons = 0;
  sfq_top DUT (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_write_clock(pin[1:0]), .i_wr_en(en[1:0]), .i_wr_data(wdata),
    .i_offset_load_strobe(ldstb),
    .i_read_clock(pin[3:2]), .i_rd_en(en[3:2]), .o_rd_data(rdata),
    // bank 0 code 110, bank 1 code 101
    .i_chain_head_select(2'h3), .i_read_chain_in(2'h1), .i_write_chain_in(2'h2),
    .o_empty_indicator(empty), .o_full_indicator(full), .o_almost_empty_flag(aempty),
    .o_almost_full_flag(afull), .o_irq(irq));
  sfq_far_end #(.HALF(2)) u_far (
    .i_clk_sys(i_clk_sys), .i_want(want), .o_pin(pin), .o_en(en), .o_done(done));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] cfg(input [2:0] c);
    cfg = {3'h0, c[1] & c[0], c[0] & ~c[1], c};
  endfunction
  task chk(input [35:0] seen, input [35:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      @(posedge i_clk_sys);
      while (pready !== 1'b1)
        @(posedge i_clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_done(input integer k);
    begin
      @(posedge i_clk_sys);
      while (done[k] !== 1'b1)
        @(posedge i_clk_sys);
    end
  endtask
  // keep low marks a write that the bank must refuse
  task push(input b, input integer n, input keep);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        seed = lfsr(seed);
        wdata <= {2{seed[17:0]}};
        want[b] <= 1'b1;
        if (keep)
          q.push_back(seed[17:0]);
        wait_done(b);
      end
      want[b] <= 1'b0;
    end
  endtask
  // bank 1 shows its head before a read, bank 0 one read later
  task pop(input b, input integer n);
    integer i;
    reg [17:0] last;
    begin
      want[2+b] <= 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        wait_done(2 + b);
        if (b)
          chk(rdata[35:18], q.pop_front());
        else if (i > 0)
          chk(rdata[17:0], last);
        if (!b)
          last = q.pop_front();
      end
      want[2+b] <= 1'b0;
      cyc(12);
      if (!b)
        chk(rdata[17:0], last);
      chk(empty[b], q.size() == 0);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #2000000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    cyc(20);
    i_srst <= 1'b0;
    chk({empty, full, aempty, afull}, 8'hcc);
    apb(0, `SFQ_REG_CONFIG, 0);
    chk(rd, {16'h0, cfg(3'h5), cfg(3'h6)});
    apb(0, 8'h40, 0);
    chk({err, rd}, 33'h100000000);
    apb(1, `SFQ_REG_MASK, 32'h1);
    push(0, 1, 1);
    cyc(1);
    // first read edge that sees the word only fills the first stage
    @(posedge pin[2]);
    cyc(2);
    chk(empty[0], 1'b1);
    @(posedge pin[2]);
    cyc(2);
    chk(empty[0], 1'b0);
    push(0, 254, 1);
    cyc(12);
    chk({full[0], afull[0], aempty[0], irq}, 4'h4);
    push(0, 1, 1);
    cyc(12);
    chk({full[0], irq}, 2'h3);
    push(0, 1, 0);
    cyc(12);
    apb(0, `SFQ_REG_LEVEL, 0);
    chk(rd, 32'h00000100);
    apb(0, `SFQ_REG_STATUS, 0);
    chk(rd, 32'h00000017);
    apb(1, `SFQ_REG_STATUS, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
    pop(0, 1);
    chk(full[0], 1'b0);
    pop(0, 255);
    $display("test bank 0 done");
    // a write under the load strobe must not reach the array
    ldstb <= 2'h2;
    push(1, 1, 0);
    ldstb <= 2'h0;
    cyc(12);
    chk(empty[1], 1'b1);
    push(1, 1, 1);
    repeat (3) @(posedge pin[3]);
    cyc(2);
    chk({empty, rdata[35:18]}, {2'h1, q[0]});
    push(1, 256, 1);
    cyc(12);
    apb(0, `SFQ_REG_LEVEL, 0);
    chk({full[1], rd}, {1'b1, 32'h01010000});
    pop(1, 257);
    $display("test bank 1 done");
    give_verdict;
  end
endmodule
